// ==== logic/slc_pkg.sv ====
// constants for the switch link configuration and status register bank
package slc_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] PLS_IDX = 8'h40; // processor link status, 8 words
  localparam logic [7:0] ELC_IDX = 8'h80; // external link config, 8 words
  localparam logic [7:0] SFC_IDX = 8'hA0; // static forwarding, 8 words
  localparam logic [7:0] IST_IDX = 8'hC0; // interrupt status, w1c
  localparam logic [7:0] IMK_IDX = 8'hC1; // interrupt mask
  // processor link status fields
  localparam int PLS_KIND_LSB = 24; // source kind, 2 bits
  localparam int PLS_DEST_LSB = 16; // destination link, 8 bits
  localparam int PLS_NET_LSB = 4; // network number, 2 bits
  localparam int PLS_JUNK_BIT = 2; // junk packet flag
  localparam int PLS_DBUSY_BIT = 1; // destination side in use
  localparam int PLS_SBUSY_BIT = 0; // source side in use
  // external link config fields
  localparam int ELC_EN_BIT = 31; // link enable
  localparam int ELC_WIDE_BIT = 30; // five wire mode
  localparam int ELC_ERR_BIT = 27; // receive error
  localparam int ELC_ISSUED_BIT = 26; // credit issued to remote
  localparam int ELC_HELD_BIT = 25; // credit held locally
  localparam int ELC_CRST_BIT = 24; // credit reset, write only
  localparam int ELC_RRST_BIT = 23; // receiver reset, write only
  localparam int ELC_SYMGAP_LSB = 11; // symbol gap, 11 bits
  localparam int ELC_TOKGAP_LSB = 0; // token gap, 11 bits
  localparam int GAP_W = 11; // width of both gap counts
  // static forwarding fields
  localparam int SFC_EN_BIT = 31; // forwarding enable
  localparam int SFC_PROC_BIT = 8; // destination processor
  localparam int SFC_CHAN_LSB = 0; // destination channel end, 5 bits
  // reset values
  localparam logic [1:0] NET_RST = 2'h0; // network number
  localparam logic [GAP_W-1:0] GAP_RST = 11'h000; // both gaps
  localparam logic [31:0] ZERO32 = 32'h0000_0000; // reserved bits
  // source kinds
  typedef enum logic [1:0] {SK_SERIAL, SK_PROC, SK_CTRL, SK_UNDEF} slc_kind_t;
endpackage

// ==== logic/slc_regs.sv ====
// apb register bank with link gap pacing, credit flags and static forwarding
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Contract
// - status shows two-bit source kind per link
// - status shows destination link while in use
// - writable network field, resets to zero
// - junk packet flag, read only
// - destination-busy and source-busy flags, read only
// - enable bit turns external link on/off
// - width bit: clear two wires, set five
// - error on overflow or illegal token
// - credit-issued flag, zero after reset
// - credit-held flag, zero after reset
// - credit reset drops credit, sends greeting
// - receiver reset restarts token framing
// - symbol gap at least count plus one
// - token gap at least count plus one
// - static forwarding bypasses routing when enabled
// - static destination processor and channel fields
// - config registers from base control links 0-7
module slc_regs import slc_pkg::*; #(
  parameter int NL = 8 // links per register group
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic irq, // level interrupt
  input wire logic [2*NL-1:0] pl_kind, // per processor link source kind
  input wire logic [8*NL-1:0] pl_dest, // per link destination number
  input wire logic [NL-1:0] pl_junk, // packet being discarded
  input wire logic [NL-1:0] pl_dbusy, // destination side busy
  input wire logic [NL-1:0] pl_sbusy, // source side busy
  output logic [2*NL-1:0] pl_net, // network number per link
  input wire logic [NL-1:0] xl_rx_ovf, // receive buffer overflow pulse
  input wire logic [NL-1:0] xl_rx_bad, // illegal token pulse
  input wire logic [NL-1:0] xl_credit_in, // remote granted us credit, pulse
  input wire logic [NL-1:0] xl_credit_out, // we granted remote credit, pulse
  input wire logic [NL-1:0] xl_tx_req, // symbol waiting to send
  input wire logic [NL-1:0] xl_tx_last, // waiting symbol ends a token
  output logic [NL-1:0] xl_tx_go, // send the symbol now, pulse
  output logic [NL-1:0] xl_enable, // link enabled, also pin mux select
  output logic [NL-1:0] xl_wide, // five wire mode
  output logic [NL-1:0] xl_greeting, // send greeting token, pulse
  output logic [NL-1:0] xl_rx_reset, // receiver reset, pulse
  output logic [NL-1:0] sf_enable, // static forwarding, by link letter a..h
  output logic [NL-1:0] sf_proc, // static destination processor
  output logic [5*NL-1:0] sf_chan // static destination channel end
);

  // the register index within a group is three bits wide
  if (NL < 1 || NL > 8) begin : g_nl_check
    $error("slc_regs: NL must be 1..8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // static register index to link letter: c,d,a,b,g,h,e,f
  function automatic logic [2:0] sf_letter(input logic [2:0] idx);
    sf_letter = idx ^ 3'h2;
  endfunction

  // word decode of a group base
  function automatic logic hit(input logic [7:0] widx, input logic [7:0] base);
    hit = (widx >= base) && (widx < base + 8'(NL));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic [7:0] widx; // word index of the access
  logic [2:0] sub; // register within its group
  logic hit_pls, hit_elc, hit_sfc, hit_ist, hit_imk; // group hits
  logic mapped; // address lands on a register
  logic setup_ok; // first access cycle, answer next edge
  logic wr_done; // completing write edge

  assign widx = paddr[9:2];
  assign sub = widx[2:0];
  assign hit_pls = hit(widx, PLS_IDX) && (paddr[11:10] == 2'h0);
  assign hit_elc = hit(widx, ELC_IDX) && (paddr[11:10] == 2'h0);
  assign hit_sfc = hit(widx, SFC_IDX) && (paddr[11:10] == 2'h0);
  assign hit_ist = (widx == IST_IDX) && (paddr[11:10] == 2'h0);
  assign hit_imk = (widx == IMK_IDX) && (paddr[11:10] == 2'h0);
  assign mapped = hit_pls | hit_elc | hit_sfc | hit_ist | hit_imk;
  assign setup_ok = psel & penable & ~pready;
  // no write lands on an unmapped word
  assign wr_done = psel & penable & pready & pwrite & mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  logic [1:0] net_q [NL]; // network per processor link
  logic [NL-1:0] en_q, wide_q; // enable and width
  logic [NL-1:0] err_q, issued_q, held_q; // link flags
  logic [GAP_W-1:0] sgap_q [NL]; // symbol gap per link
  logic [GAP_W-1:0] tgap_q [NL]; // token gap per link
  logic [GAP_W:0] cnt_q [NL]; // spacing countdown per link
  logic [NL-1:0] sfen_q, sfproc_q; // static enable, processor
  logic [4:0] sfch_q [NL]; // static channel end
  logic [NL-1:0] greet_q, rxrst_q, go_q; // pulse outputs
  logic [2*NL-1:0] ist_q, imk_q; // interrupt status and mask
  logic irq_q; // interrupt output flop
  logic [31:0] rdata_q; // read data flop
  logic ready_q, err_ack_q; // apb answer flops

  // write strobes of the per-link groups
  logic [NL-1:0] wr_pls, wr_elc, wr_sfc; // one-hot by word
  logic [NL-1:0] crst, rrst; // write-only actions

  always_comb begin
    for (int i = 0; i < NL; i++) begin
      wr_pls[i] = wr_done & hit_pls & (sub == 3'(i));
      wr_elc[i] = wr_done & hit_elc & (sub == 3'(i));
      wr_sfc[i] = wr_done & hit_sfc & (sub == 3'(i));
      crst[i] = wr_elc[i] & pwdata[ELC_CRST_BIT];
      rrst[i] = wr_elc[i] & pwdata[ELC_RRST_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // processor link network fields

  // network field, reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NL; i++) net_q[i] <= NET_RST;
    end else begin
      for (int i = 0; i < NL; i++)
        if (wr_pls[i]) net_q[i] <= pwdata[PLS_NET_LSB +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // external link control and flags

  // enable, width, gaps; disabled after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= '0;
      wide_q <= '0;
      for (int i = 0; i < NL; i++) begin
        sgap_q[i] <= GAP_RST;
        tgap_q[i] <= GAP_RST;
      end
    end else begin
      for (int i = 0; i < NL; i++)
        if (wr_elc[i]) begin
          en_q[i] <= pwdata[ELC_EN_BIT];
          wide_q[i] <= pwdata[ELC_WIDE_BIT];
          sgap_q[i] <= pwdata[ELC_SYMGAP_LSB +: GAP_W];
          tgap_q[i] <= pwdata[ELC_TOKGAP_LSB +: GAP_W];
        end
    end
  end

  // error and credit flags; a disabled link holds no credit
  // the error clears only on a receiver reset so software can see it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= '0;
      issued_q <= '0;
      held_q <= '0;
    end else begin
      for (int i = 0; i < NL; i++) begin
        // set wins over the receiver reset clear
        if (en_q[i] & (xl_rx_ovf[i] | xl_rx_bad[i])) err_q[i] <= 1'b1;
        else if (rrst[i]) err_q[i] <= 1'b0;
        if (!en_q[i]) issued_q[i] <= 1'b0;
        else if (xl_credit_out[i]) issued_q[i] <= 1'b1;
        // a grant landing with a credit reset wins, as a set beats a clear
        if (!en_q[i]) held_q[i] <= 1'b0;
        else if (xl_credit_in[i]) held_q[i] <= 1'b1;
        else if (crst[i]) held_q[i] <= 1'b0;
      end
    end
  end

  // one-cycle action pulses toward the link logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      greet_q <= '0;
      rxrst_q <= '0;
    end else begin
      greet_q <= crst;
      rxrst_q <= rrst;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit pacing

  // a granted symbol loads gap+1; the next grant waits for zero,
  // so at least gap+1 idle clocks stand between two grants
  logic [NL-1:0] go_d; // grant this cycle
  always_comb begin
    for (int i = 0; i < NL; i++)
      go_d[i] = en_q[i] & held_q[i] & xl_tx_req[i] & ~go_q[i] & (cnt_q[i] == '0);
  end

  // spacing counters and grant pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      go_q <= '0;
      for (int i = 0; i < NL; i++) cnt_q[i] <= '0;
    end else begin
      go_q <= go_d;
      for (int i = 0; i < NL; i++) begin
        if (go_d[i] & xl_tx_last[i]) cnt_q[i] <= {1'b0, tgap_q[i]} + 1'b1;
        else if (go_d[i]) cnt_q[i] <= {1'b0, sgap_q[i]} + 1'b1;
        else if (cnt_q[i] != '0) cnt_q[i] <= cnt_q[i] - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // static forwarding

  // fields stored by register index, driven out by link letter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfen_q <= '0;
      sfproc_q <= '0;
      for (int i = 0; i < NL; i++) sfch_q[i] <= 5'h00;
    end else begin
      for (int i = 0; i < NL; i++)
        if (wr_sfc[i]) begin
          sfen_q[i] <= pwdata[SFC_EN_BIT];
          sfproc_q[i] <= pwdata[SFC_PROC_BIT];
          sfch_q[i] <= pwdata[SFC_CHAN_LSB +: 5];
        end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts: bits 0..NL-1 link error, NL..2NL-1 credit gained

  logic [2*NL-1:0] ev; // event pulses
  logic [2*NL-1:0] ist_clr; // write-one-to-clear
  assign ev = {xl_credit_in & en_q & ~held_q, en_q & (xl_rx_ovf | xl_rx_bad)};
  assign ist_clr = (wr_done & hit_ist) ? pwdata[2*NL-1:0] : '0;

  // sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      imk_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~ist_clr) | ev;
      if (wr_done & hit_imk) imk_q <= pwdata[2*NL-1:0];
      irq_q <= |(((ist_q & ~ist_clr) | ev) & imk_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  logic [31:0] rd_pls, rd_elc, rd_sfc, rd_d; // read words
  logic [2:0] k; // in-range link index
  // compare as int: a three-bit cast of eight would wrap to zero
  assign k = (int'(sub) < NL) ? sub : 3'h0;

  always_comb begin
    rd_pls = ZERO32;
    rd_pls[PLS_KIND_LSB +: 2] = pl_kind[2*k +: 2];
    // destination reads zero while the link is idle
    if (pl_sbusy[k] | pl_dbusy[k]) rd_pls[PLS_DEST_LSB +: 8] = pl_dest[8*k +: 8];
    rd_pls[PLS_NET_LSB +: 2] = net_q[k];
    rd_pls[PLS_JUNK_BIT] = pl_junk[k];
    rd_pls[PLS_DBUSY_BIT] = pl_dbusy[k];
    rd_pls[PLS_SBUSY_BIT] = pl_sbusy[k];
    rd_elc = ZERO32; // write-only bits read zero
    rd_elc[ELC_EN_BIT] = en_q[k];
    rd_elc[ELC_WIDE_BIT] = wide_q[k];
    rd_elc[ELC_ERR_BIT] = err_q[k];
    rd_elc[ELC_ISSUED_BIT] = issued_q[k];
    rd_elc[ELC_HELD_BIT] = held_q[k];
    rd_elc[ELC_SYMGAP_LSB +: GAP_W] = sgap_q[k];
    rd_elc[ELC_TOKGAP_LSB +: GAP_W] = tgap_q[k];
    rd_sfc = ZERO32;
    rd_sfc[SFC_EN_BIT] = sfen_q[k];
    rd_sfc[SFC_PROC_BIT] = sfproc_q[k];
    rd_sfc[SFC_CHAN_LSB +: 5] = sfch_q[k];
    rd_d = ZERO32;
    if (hit_pls) rd_d = rd_pls;
    else if (hit_elc) rd_d = rd_elc;
    else if (hit_sfc) rd_d = rd_sfc;
    else if (hit_ist) rd_d[2*NL-1:0] = ist_q;
    else if (hit_imk) rd_d[2*NL-1:0] = imk_q;
  end

  // one wait state: ready rises on the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      err_ack_q <= 1'b0;
      rdata_q <= ZERO32;
    end else begin
      ready_q <= setup_ok;
      err_ack_q <= setup_ok & ~mapped;
      if (setup_ok) rdata_q <= pwrite ? ZERO32 : rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  assign pready = ready_q;
  assign pslverr = err_ack_q;
  assign prdata = rdata_q;
  assign irq = irq_q;
  assign xl_enable = en_q;
  assign xl_wide = wide_q;
  assign xl_greeting = greet_q;
  assign xl_rx_reset = rxrst_q;
  assign xl_tx_go = go_q;

  // network outputs and the letter-ordered static fields
  always_comb begin
    for (int i = 0; i < NL; i++) pl_net[2*i +: 2] = net_q[i];
    sf_enable = '0;
    sf_proc = '0;
    sf_chan = '0;
    for (int i = 0; i < NL; i++) begin
      if (int'(sf_letter(3'(i))) < NL) begin
        sf_enable[sf_letter(3'(i))] = sfen_q[i];
        sf_proc[sf_letter(3'(i))] = sfproc_q[i];
        sf_chan[5*sf_letter(3'(i)) +: 5] = sfch_q[i];
      end
    end
  end

endmodule
`default_nettype wire

// ==== sim/slc_regs_checker.sv ====
// port-level assertions for the switch link register bank
`timescale 1ns/10ps
`default_nettype none
module slc_regs_checker #(
  parameter int NL = 8 // links per group
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [NL-1:0] xl_tx_req, // symbol waiting
  input wire logic [NL-1:0] xl_tx_go, // send pulse
  input wire logic [NL-1:0] xl_enable, // link on
  input wire logic [NL-1:0] xl_wide, // five wire mode
  input wire logic [NL-1:0] xl_greeting, // greeting pulse
  input wire logic [2*NL-1:0] pl_net, // networks
  input wire logic [NL-1:0] sf_enable // forwarding on
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wdone = psel && penable && pready && pwrite; // write lands here
  wire logic [1:0] wmode = pwdata[31:30]; // enable and width bits
  wire logic [1:0] wnet = pwdata[5:4]; // network field
  wire logic wfwd = pwdata[31]; // forwarding enable
  // bus answers after exactly one wait state
  a_one_wait: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("ready not one cycle after access start");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  // a send on link 0 is always followed by at least one idle cycle
  a_go_alone: assert property (xl_tx_go[0] |=> !xl_tx_go[0])
    else $error("sends on adjacent cycles");
  a_go_cause: assert property ((xl_tx_go & ~($past(xl_tx_req) & $past(xl_enable))) == '0)
    else $error("send without request or with link off");
  a_mode_write: assert property (wdone && paddr == 12'h200 |=> {xl_enable[0], xl_wide[0]} == $past(wmode))
    else $error("enable or width output not following write");
  a_net_write: assert property (wdone && paddr == 12'h100 |=> pl_net[1:0] == $past(wnet))
    else $error("network output not following write");
  // first forwarding word belongs to link c
  a_fwd_order: assert property (wdone && paddr == 12'h280 |=> sf_enable[2] == $past(wfwd))
    else $error("forwarding word not mapped to its link");
  a_greet_pulse: assert property (wdone && paddr == 12'h200 && pwdata[31] && pwdata[24]
    |=> xl_greeting[0] ##1 !xl_greeting[0])
    else $error("greeting not a single pulse after credit reset");
  c_send: cover property (xl_tx_go[0]);
  c_refused: cover property (pslverr);
  c_greet: cover property (xl_greeting[0]);
endmodule
`default_nettype wire

// ==== sim/slc_link_model.sv ====
// far-end link model: keeps symbols requested and logs the spacing of sends
`timescale 1ns/10ps
`default_nettype none
module slc_link_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic go, // send pulse
  input wire logic run, // traffic wanted
  output logic req, // symbol waiting
  output logic last, // symbol ends token
  output var int gap_sym, // least gap after plain symbol
  output var int gap_tok, // least gap after token end
  output var int n_go // symbols sent
);
  int cnt_q; // cycles since last send
  // a pending symbol is held until taken, even once traffic stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 1'b0;
      last <= 1'b0;
      cnt_q <= 0;
      n_go <= 0;
      gap_sym <= 0;
      gap_tok <= 0;
    end else begin
      req <= run | (req & ~go);
      cnt_q <= go ? 1 : cnt_q + 1;
      if (go) begin // tokens of two symbols
        last <= ~last;
        n_go <= n_go + 1;
        if (n_go > 0 && !last && (gap_tok == 0 || cnt_q < gap_tok)) gap_tok <= cnt_q;
        if (n_go > 0 && last && (gap_sym == 0 || cnt_q < gap_sym)) gap_sym <= cnt_q;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/switch_link_config_status_test.sv ====
// self-checking bench for the switch link register bank
`timescale 1ns/10ps
`default_nettype none
module switch_link_config_status_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
  logic [11:0] paddr = 12'h000; // byte address
  logic [31:0] pwdata = 32'h0000_0000, prdata; // bus data
  logic pready, pslverr, irq, req, last; // answers
  logic [15:0] pl_kind = 16'h0000, pl_net; // kinds, networks
  logic [63:0] pl_dest = 64'h0; // destinations
  logic [7:0] pl_junk = 8'h00, pl_dbusy = 8'h00, pl_sbusy = 8'h00, ovf = 8'h00, bad = 8'h00, cin = 8'h00, cout = 8'h00;
  logic [7:0] go, en, wide, greet, rrst, sfe, sfp; // link outputs
  logic [39:0] sfc; // channel ends
  int gs, gt, ng, bad_count = 0, checks = 0; // spacing log, tallies
  always #2.5 pclk = ~pclk; // 200 MHz
  slc_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
    .pl_kind, .pl_dest, .pl_junk, .pl_dbusy, .pl_sbusy, .pl_net, .xl_rx_ovf(ovf), .xl_rx_bad(bad),
    .xl_credit_in(cin), .xl_credit_out(cout), .xl_tx_req({7'h00, req}), .xl_tx_last({7'h00, last}),
    .xl_tx_go(go), .xl_enable(en), .xl_wide(wide), .xl_greeting(greet), .xl_rx_reset(rrst),
    .sf_enable(sfe), .sf_proc(sfp), .sf_chan(sfc));
  slc_link_model far (.pclk, .presetn, .go(go[0]), .run, .req, .last, .gap_sym(gs), .gap_tok(gt), .n_go(ng));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one bus transfer; request held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin // hung bus
      bad_count++;
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk(r, exp);
  endtask
  task automatic t_reset;
    rd(12'h100, 32'h0000_0000);
    rd(12'h200, 32'h0000_0000);
    rd(12'h280, 32'h0000_0000);
    $display("reset values done");
  endtask
  // every source kind, busy and idle destination, then writes to read-only bits
  task automatic t_status;
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      pl_kind[3:2] <= k;
      pl_dest[15:8] <= 8'hA4 | {6'h00, k};
      pl_junk[1] <= k[0];
      pl_dbusy[1] <= k[1];
      pl_sbusy[1] <= ^k;
      rd(12'h104, {6'h00, k, (k != 2'b00) ? (8'hA4 | {6'h00, k}) : 8'h00, 13'h0000, k[0], k[1], ^k});
    end
    wr(12'h104, 32'hFFFF_FFFF);
    rd(12'h104, 32'h03A7_0036);
    chk(32'(pl_net), 32'h0000_000C);
    $display("status done");
  endtask
  task automatic t_cfg;
    logic [31:0] r;
    logic e;
    wr(12'h21C, 32'hFFFF_FFFF);
    @(posedge pclk);
    chk(32'({en[7], wide[7]}), 32'h0000_0003);
    rd(12'h21C, 32'hC03F_FFFF);
    wr(12'h21C, 32'h0000_0000);
    @(posedge pclk);
    chk(32'({en[7], wide[7]}), 32'h0000_0000);
    apb(1'b0, 12'h220, 32'h0000_0000, r, e);
    chk(32'({e, r[3:0]}), 32'h0000_0010);
    $display("config done");
  endtask
  // no credit means no send; then spacing with symbol gap 1, token gap 3
  task automatic t_pace;
    logic g = 1'b0;
    wr(12'h200, 32'h8000_0803);
    run <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(32'(ng), 32'h0000_0000);
    cin <= 8'h01;
    cout <= 8'h01;
    @(posedge pclk);
    cin <= 8'h00;
    cout <= 8'h00;
    rd(12'h200, 32'h8600_0803);
    repeat (60) @(posedge pclk);
    run <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'(ng > 4), 32'h0000_0001);
    chk(32'(gs >= 3), 32'h0000_0001);
    chk(32'(gt >= 5), 32'h0000_0001);
    wr(12'h200, 32'h8100_0803);
    repeat (3) begin
      @(posedge pclk);
      g = g | greet[0];
    end
    chk(32'(g), 32'h0000_0001);
    rd(12'h200, 32'h8400_0803);
    $display("pacing done");
  endtask
  // masked and unmasked events, write-one-clear, receiver reset
  task automatic t_irq;
    logic g = 1'b0;
    wr(12'h300, 32'h0000_FFFF);
    wr(12'h304, 32'h0000_0001);
    wr(12'h204, 32'h8000_0000); // link 1 on, so its error counts
    bad <= 8'h01;
    ovf <= 8'h02;
    @(posedge pclk);
    bad <= 8'h00;
    ovf <= 8'h00;
    rd(12'h300, 32'h0000_0003);
    chk(32'(irq), 32'h0000_0001);
    wr(12'h300, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk(32'(irq), 32'h0000_0000);
    rd(12'h200, 32'h8C00_0803);
    wr(12'h200, 32'h8080_0803);
    repeat (3) begin
      @(posedge pclk);
      g = g | rrst[0];
    end
    chk(32'(g), 32'h0000_0001);
    rd(12'h200, 32'h8400_0803);
    $display("interrupt done");
  endtask
  task automatic t_static;
    for (int i = 0; i < 8; i++) begin
      wr(12'h280 + 12'(4 * i), 32'h8000_0100 | 32'(i));
      rd(12'h280 + 12'(4 * i), 32'h8000_0100 | 32'(i));
      chk(32'(sfc[5 * (i ^ 2) +: 5]), 32'(i));
    end
    chk(32'({sfe, sfp}), 32'h0000_FFFF);
    $display("forwarding done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_cfg();
    t_pace();
    t_irq();
    t_static();
    close_out();
  end
endmodule
bind slc_regs slc_regs_checker #(.NL(NL)) chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .xl_tx_req, .xl_tx_go, .xl_enable, .xl_wide, .xl_greeting, .pl_net, .sf_enable);
`default_nettype wire
